/* File: shared/imcc_pkg.sv */
// Package for the IMU mode and command controller
package imcc_pkg;
	// ----------------------------------------
	// Register map (word byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_LATENCY = 8'h08;
	localparam logic [7:0] ADDR_TRIM_BASE = 8'h10;
	localparam logic [7:0] ADDR_TRIM_LAST = 8'h24;
	localparam logic [7:0] ADDR_LAST_CMD = 8'h28;
	localparam logic [7:0] ADDR_FAULT_ACC = 8'h2c;
	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int CTRL_MAINT_EXIT = 0;
	localparam int CTRL_EXIT_NORMAL = 1;
	localparam int CTRL_TRIM_EXIT = 2;
	localparam int CTRL_FAULT_QUERY = 3;
	localparam int CTRL_EXT_TRIG = 4;
	localparam int CTRL_SUBSAMPLED = 5;
	localparam int CTRL_INCREMENTAL = 6;
	// ----------------------------------------
	// Characters and widths
	// ----------------------------------------
	localparam logic [7:0] CHAR_CR = 8'h0d;
	localparam logic [7:0] CHAR_N = 8'h4e;
	localparam logic [7:0] CHAR_I = 8'h49;
	localparam logic [7:0] CHAR_C = 8'h43;
	localparam logic [7:0] CHAR_T = 8'h54;
	localparam logic [7:0] CHAR_E = 8'h45;
	localparam logic [7:0] CHAR_R = 8'h52;
	localparam int CMD_BUF_LEN = 11;
	localparam int SAMPLE_W = 24;
	localparam int AXES = 6;
	localparam int STATUS_W = 8;
	localparam int LATENCY_W = 16;
	localparam logic [CMD_BUF_LEN*8-1:0] WORD_MAINT = 88'h53_45_52_56_49_43_45_4d_4f_44_45;
	localparam logic [CMD_BUF_LEN*8-1:0] WORD_TRIM = 88'h00_00_00_00_42_54_4f_4d_4f_44_45;
	localparam logic [7:0] WORD_MAINT_LEN = 8'h0b;
	localparam logic [7:0] WORD_TRIM_LEN = 8'h07;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		CMD_NONE, CMD_PART, CMD_SERIAL, CMD_CONFIG, CMD_TRIM_DG, CMD_FAULT_DG
	} imcc_special_t;
	typedef enum {MODE_INIT, MODE_NORMAL, MODE_MAINT, MODE_TRIM} imcc_mode_t;
	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} imcc_char_t;
	typedef struct packed {
		logic [SAMPLE_W-1:0] value;
		logic [STATUS_W-1:0] fault;
	} imcc_sample_t;
endpackage

/* File: design/imcc_top.sv */
// IMU mode and command controller with Wishbone register access
//
// What this block does
// - Latency sent as 16-bit microseconds, MSB first
// - Output equals compensated value plus trim offset
// - Trim offsets kept in rate/g units always
// - Maintenance entry answers with information listing
// - Maintenance mode samples silently, discards data
// - External reset in maintenance returns to init
// - Exit selects init or normal, keeps changes
// - Trim entry stops datagrams, acknowledges, keeps measuring
// - Trim exit resumes normal periodic datagrams
// - Status bits OR over sub-samples
// - Status bits cleared after each transmission
// - Fault registers cleared at start, datagram, query
// - Carriage return executes buffered command
// - No echo, act only on valid command
// - Increments during special datagram are lost
// - Special datagram takes next slot(s)
// - External trigger sends special at next trigger
// - Self-check results feed status reporting
// - Finish current datagram before mode change
`timescale 1ns/1ps
module imcc_top (
	input wire logic core_clk_in, // 40 MHz clock
	input wire logic reset_n_in, // Sync reset, active low
	input wire logic [7:0] rx_char_in, // Received serial character
	input wire logic rx_valid_in, // Character strobe, one cycle
	input wire logic slot_tick_in, // Output slot or trigger pulse
	input wire logic tx_busy_in, // Datagram transmitter busy
	input wire logic [imcc_pkg::SAMPLE_W-1:0] comp_value_in, // Compensated sample
	input wire logic [2:0] comp_axis_in, // Axis of sample
	input wire logic comp_valid_in, // Sample strobe
	input wire logic [imcc_pkg::STATUS_W-1:0] check_fault_in, // Self-check faults
	input wire logic [imcc_pkg::LATENCY_W-1:0] latency_us_in, // Latency count
	input wire logic [7:0] wb_adr_in, // Wishbone address
	input wire logic [31:0] wb_dat_in, // Wishbone write data
	input wire logic [3:0] wb_sel_in, // Wishbone byte selects
	input wire logic wb_we_in, // Wishbone write
	input wire logic wb_cyc_in, // Wishbone cycle
	input wire logic wb_stb_in, // Wishbone strobe
	output logic [31:0] wb_dat_out, // Wishbone read data
	output logic wb_ack_out, // Wishbone acknowledge
	output logic [imcc_pkg::SAMPLE_W-1:0] adj_value_out, // Trimmed sample
	output logic [2:0] adj_axis_out, // Axis of trimmed sample
	output logic adj_valid_out, // Trimmed sample strobe
	output logic [imcc_pkg::STATUS_W-1:0] status_byte_out, // Status byte for slot
	output logic [7:0] latency_upper_byte_out, // Latency MSB
	output logic [7:0] latency_lower_byte_out, // Latency LSB
	output logic send_measure_out, // Send measurement in slot
	output logic [2:0] send_special_out, // Special datagram kind
	output logic send_listing_out, // Send information listing
	output logic send_trim_ack_out, // Send trim mode acknowledge
	output logic incr_discard_out, // Drop accumulated increments
	output logic unit_reset_out, // Unit reset request
	output logic [1:0] mode_out // Current mode code
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [imcc_pkg::CMD_BUF_LEN*8-1:0] buf_reg;
	logic [7:0] len_reg;
	logic [7:0] sync1_reg, sync2_reg;
	logic v1_reg, v2_reg;
	imcc_pkg::imcc_char_t ch;
	imcc_pkg::imcc_mode_t mode_reg;
	imcc_pkg::imcc_special_t pend_reg;
	logic pend_maint_reg, pend_trim_reg;
	logic [imcc_pkg::SAMPLE_W-1:0] trim_reg [imcc_pkg::AXES];
	logic [imcc_pkg::STATUS_W-1:0] stat_acc_reg;
	logic [imcc_pkg::STATUS_W-1:0] fault_acc_reg;
	logic [6:0] ctrl_reg;
	logic [7:0] last_cmd_reg;
	logic exec_single, exec_maint, exec_trim, exec_any;
	logic slot_free, fault_dg_sent, query_clear;
	logic wb_hit, wb_wr;
	logic [imcc_pkg::STATUS_W-1:0] fault_now;

	// Serial character inputs pass two flip-flops
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
			v1_reg <= 1'b0;
			v2_reg <= 1'b0;
		end else begin
			sync1_reg <= rx_char_in;
			sync2_reg <= sync1_reg;
			v1_reg <= rx_valid_in;
			v2_reg <= v1_reg;
		end
	end
	assign ch = '{data: sync2_reg, valid: v2_reg};

	// ----------------------------------------
	// Command recognition
	// ----------------------------------------
	function automatic logic word_match(input logic [imcc_pkg::CMD_BUF_LEN*8-1:0] b,
			input logic [7:0] l, input logic [imcc_pkg::CMD_BUF_LEN*8-1:0] w,
			input logic [7:0] wl);
		word_match = (l == wl) && (b == w);
	endfunction

	// Only complete upper-case commands count; case differences fall out
	always_comb begin
		exec_single = 1'b0;
		exec_maint = 1'b0;
		exec_trim = 1'b0;
		if (ch.valid && ch.data == imcc_pkg::CHAR_CR && mode_reg == imcc_pkg::MODE_NORMAL) begin
			exec_single = (len_reg == 8'h01);
			exec_maint = word_match(buf_reg, len_reg, imcc_pkg::WORD_MAINT,
				imcc_pkg::WORD_MAINT_LEN);
			exec_trim = word_match(buf_reg, len_reg, imcc_pkg::WORD_TRIM,
				imcc_pkg::WORD_TRIM_LEN);
		end
	end
	assign exec_any = exec_single || exec_maint || exec_trim;

	// Shift buffer; any CR empties it, recognised or not
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			buf_reg <= '0;
			len_reg <= 8'h00;
		end else if (ch.valid) begin
			if (ch.data == imcc_pkg::CHAR_CR) begin
				buf_reg <= '0;
				len_reg <= 8'h00;
			end else begin
				buf_reg <= {buf_reg[imcc_pkg::CMD_BUF_LEN*8-9:0], ch.data};
				len_reg <= (len_reg == 8'hff) ? len_reg : len_reg + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// Special datagram requests
	// ----------------------------------------
	assign slot_free = slot_tick_in && !tx_busy_in;
	assign fault_dg_sent = slot_free && pend_reg == imcc_pkg::CMD_FAULT_DG
		&& mode_reg == imcc_pkg::MODE_NORMAL;

	// Held until the next slot or trigger takes it; later request replaces
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			pend_reg <= imcc_pkg::CMD_NONE;
			last_cmd_reg <= 8'h00;
			unit_reset_out <= 1'b0;
		end else begin
			unit_reset_out <= 1'b0;
			if (slot_free && mode_reg == imcc_pkg::MODE_NORMAL)
				pend_reg <= imcc_pkg::CMD_NONE;
			if (exec_single) begin
				last_cmd_reg <= buf_reg[7:0];
				unique case (buf_reg[7:0])
					imcc_pkg::CHAR_N: pend_reg <= imcc_pkg::CMD_PART;
					imcc_pkg::CHAR_I: pend_reg <= imcc_pkg::CMD_SERIAL;
					imcc_pkg::CHAR_C: pend_reg <= imcc_pkg::CMD_CONFIG;
					imcc_pkg::CHAR_T: pend_reg <= imcc_pkg::CMD_TRIM_DG;
					imcc_pkg::CHAR_E: pend_reg <= imcc_pkg::CMD_FAULT_DG;
					imcc_pkg::CHAR_R: unit_reset_out <= 1'b1;
					default: ;
				endcase
			end
		end
	end

	// Slot output: special replaces measurement, nothing outside normal mode
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			send_measure_out <= 1'b0;
			send_special_out <= 3'h0;
			incr_discard_out <= 1'b0;
		end else begin
			send_measure_out <= slot_free && mode_reg == imcc_pkg::MODE_NORMAL
				&& pend_reg == imcc_pkg::CMD_NONE;
			send_special_out <= (slot_free && mode_reg == imcc_pkg::MODE_NORMAL)
				? pend_reg : 3'h0;
			incr_discard_out <= ctrl_reg[imcc_pkg::CTRL_INCREMENTAL] && slot_free
				&& mode_reg == imcc_pkg::MODE_NORMAL
				&& pend_reg != imcc_pkg::CMD_NONE;
		end
	end

	// ----------------------------------------
	// Mode control
	// ----------------------------------------
	// Entry waits out a busy transmitter and any slot, so no datagram starts after it
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			mode_reg <= imcc_pkg::MODE_INIT;
			pend_maint_reg <= 1'b0;
			pend_trim_reg <= 1'b0;
			send_listing_out <= 1'b0;
			send_trim_ack_out <= 1'b0;
		end else begin
			send_listing_out <= 1'b0;
			send_trim_ack_out <= 1'b0;
			if (exec_maint)
				pend_maint_reg <= 1'b1;
			if (exec_trim)
				pend_trim_reg <= 1'b1;
			unique case (mode_reg)
				imcc_pkg::MODE_INIT: mode_reg <= imcc_pkg::MODE_NORMAL;
				imcc_pkg::MODE_NORMAL: begin
					if (pend_maint_reg && !tx_busy_in && !slot_tick_in) begin
						mode_reg <= imcc_pkg::MODE_MAINT;
						pend_maint_reg <= 1'b0;
						send_listing_out <= 1'b1;
					end else if (pend_trim_reg && !tx_busy_in && !slot_tick_in) begin
						mode_reg <= imcc_pkg::MODE_TRIM;
						pend_trim_reg <= 1'b0;
						send_trim_ack_out <= 1'b1;
					end
				end
				imcc_pkg::MODE_MAINT: begin
					if (wb_wr && wb_adr_in == imcc_pkg::ADDR_CTRL
							&& wb_dat_in[imcc_pkg::CTRL_MAINT_EXIT])
						mode_reg <= wb_dat_in[imcc_pkg::CTRL_EXIT_NORMAL]
							? imcc_pkg::MODE_NORMAL : imcc_pkg::MODE_INIT;
				end
				imcc_pkg::MODE_TRIM: begin
					if (wb_wr && wb_adr_in == imcc_pkg::ADDR_CTRL
							&& wb_dat_in[imcc_pkg::CTRL_TRIM_EXIT])
						mode_reg <= imcc_pkg::MODE_NORMAL;
				end
			endcase
		end
	end
	assign mode_out = mode_reg[1:0];

	// ----------------------------------------
	// Trim adder and latency bytes
	// ----------------------------------------
	// Offsets in native rate/g units; no rescale by output unit
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			adj_value_out <= '0;
			adj_axis_out <= 3'h0;
			adj_valid_out <= 1'b0;
		end else begin
			adj_valid_out <= comp_valid_in && comp_axis_in < 3'(imcc_pkg::AXES);
			adj_axis_out <= comp_axis_in;
			if (comp_axis_in < 3'(imcc_pkg::AXES))
				adj_value_out <= comp_value_in + trim_reg[comp_axis_in];
		end
	end

	// Latency bytes: upper byte goes out first
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			latency_upper_byte_out <= 8'h00;
			latency_lower_byte_out <= 8'h00;
		end else begin
			latency_upper_byte_out <= latency_us_in[15:8];
			latency_lower_byte_out <= latency_us_in[7:0];
		end
	end

	// ----------------------------------------
	// Status and fault accumulation
	// ----------------------------------------
	assign fault_now = comp_valid_in ? check_fault_in : '0;

	// Per-slot OR; new faults in the slot cycle start the next window
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			stat_acc_reg <= '0;
			status_byte_out <= '0;
		end else if (slot_free) begin
			status_byte_out <= ctrl_reg[imcc_pkg::CTRL_SUBSAMPLED]
				? (stat_acc_reg | fault_now) : fault_now;
			stat_acc_reg <= fault_now;
		end else begin
			stat_acc_reg <= stat_acc_reg | fault_now;
		end
	end

	// Sticky faults; a fault arriving on a datagram or query clear cycle survives
	assign query_clear = wb_wr && wb_adr_in == imcc_pkg::ADDR_CTRL
		&& wb_dat_in[imcc_pkg::CTRL_FAULT_QUERY] && mode_reg == imcc_pkg::MODE_MAINT;
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in || mode_reg == imcc_pkg::MODE_INIT)
			fault_acc_reg <= '0;
		else if (fault_dg_sent || query_clear)
			fault_acc_reg <= fault_now;
		else
			fault_acc_reg <= fault_acc_reg | fault_now;
	end

	// ----------------------------------------
	// Wishbone slave, ack one cycle after strobe
	// ----------------------------------------
	assign wb_hit = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wb_wr = wb_hit && wb_we_in && (wb_sel_in != 4'h0);

	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			wb_ack_out <= wb_hit;
			wb_dat_out <= 32'h0000_0000;
			if (wb_hit && !wb_we_in) begin
				if (wb_adr_in == imcc_pkg::ADDR_CTRL)
					wb_dat_out <= {25'h0, ctrl_reg};
				else if (wb_adr_in == imcc_pkg::ADDR_STATUS)
					wb_dat_out <= {22'h0, pend_reg, 2'h0, mode_reg[1:0], 3'h0};
				else if (wb_adr_in == imcc_pkg::ADDR_LATENCY)
					wb_dat_out <= {16'h0, latency_us_in};
				else if (wb_adr_in == imcc_pkg::ADDR_LAST_CMD)
					wb_dat_out <= {24'h0, last_cmd_reg};
				else if (wb_adr_in == imcc_pkg::ADDR_FAULT_ACC)
					wb_dat_out <= {24'h0, fault_acc_reg};
				else if (wb_adr_in >= imcc_pkg::ADDR_TRIM_BASE
						&& wb_adr_in <= imcc_pkg::ADDR_TRIM_LAST)
					wb_dat_out <= {8'h0, trim_reg[3'((wb_adr_in - imcc_pkg::ADDR_TRIM_BASE) >> 2)]};
			end
		end
	end

	// Control: only mode-independent option bits are stored
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in)
			ctrl_reg <= 7'h00;
		else if (wb_wr && wb_adr_in == imcc_pkg::ADDR_CTRL && wb_sel_in[0])
			ctrl_reg <= {wb_dat_in[6:4], 4'h0};
	end

	// Trim offsets, byte-lane writes; cleared at reset like a reload
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			for (int a = 0; a < imcc_pkg::AXES; a++)
				trim_reg[a] <= '0;
		end else if (wb_wr && wb_adr_in >= imcc_pkg::ADDR_TRIM_BASE
				&& wb_adr_in <= imcc_pkg::ADDR_TRIM_LAST) begin
			for (int b = 0; b < 3; b++)
				if (wb_sel_in[b])
					trim_reg[3'((wb_adr_in - imcc_pkg::ADDR_TRIM_BASE) >> 2)][b*8 +: 8]
						<= wb_dat_in[b*8 +: 8];
		end
	end

	logic unused_ok;
	assign unused_ok = exec_any;
endmodule // imcc_top

/* File: dv/imcc_host_model.sv */
// Host model that sends upper-case commands over the serial character port
`timescale 1ns/1ps
module imcc_host_model (
	input wire logic core_clk_in, // Clock
	output logic [7:0] rx_char_out, // Character to device
	output logic rx_valid_out // Character strobe
);
	// ----
	// Sender
	// ----
	// Idle line starts low
	initial begin
		rx_char_out = 8'h00;
		rx_valid_out = 1'b0;
	end
	// Gaps of four cycles give the input synchroniser room; first character sits highest
	task automatic send_cmd(input logic [imcc_pkg::CMD_BUF_LEN*8-1:0] w, input int n);
		for (int i = 0; i <= n; i++) begin
			@(posedge core_clk_in);
			rx_char_out <= (i == n) ? imcc_pkg::CHAR_CR : w[8*(n-1-i) +: 8];
			rx_valid_out <= 1'b1;
			@(posedge core_clk_in);
			rx_valid_out <= 1'b0;
			rx_char_out <= ~rx_char_out; // No stale value between strobes
			repeat (3) @(posedge core_clk_in);
		end
	endtask
endmodule // imcc_host_model

/* File: dv/imcc_top_sva.sv */
// Port-level assertions for the mode and command controller
`timescale 1ns/1ps
module imcc_top_sva (
	input wire logic core_clk_in, // Clock
	input wire logic reset_n_in, // Sync reset, active low
	input wire logic slot_tick_in, // Slot pulse
	input wire logic tx_busy_in, // Transmitter busy
	input wire logic [2:0] comp_axis_in, // Sample axis
	input wire logic comp_valid_in, // Sample strobe
	input wire logic [imcc_pkg::LATENCY_W-1:0] latency_us_in, // Latency
	input wire logic [2:0] adj_axis_out, // Trimmed axis
	input wire logic adj_valid_out, // Trimmed strobe
	input wire logic [7:0] latency_upper_byte_out, // Latency MSB
	input wire logic [7:0] latency_lower_byte_out, // Latency LSB
	input wire logic send_measure_out, // Measurement slot
	input wire logic [2:0] send_special_out, // Special kind
	input wire logic send_listing_out, // Listing pulse
	input wire logic send_trim_ack_out, // Trim ack pulse
	input wire logic [1:0] mode_out // Mode code
);
	// ----
	// Properties
	// ----
	// One domain, so clock and reset are given once
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!reset_n_in);
	// Registered outputs are only trusted two edges after release
	property p_latency;
		$past(reset_n_in) && $past(reset_n_in, 2) |->
			latency_upper_byte_out == $past(latency_us_in[15:8]) &&
			latency_lower_byte_out == $past(latency_us_in[7:0]);
	endproperty
	a_latency: assert property (p_latency) else $error("latency bytes wrong");
	property p_adj;
		$past(reset_n_in) && $past(reset_n_in, 2) |->
			adj_valid_out == $past(comp_valid_in) &&
			(!adj_valid_out || adj_axis_out == $past(comp_axis_in));
	endproperty
	a_adj: assert property (p_adj) else $error("trimmed sample mispaired");
	property p_maint_quiet;
		mode_out == 2'h2 |-> !send_measure_out && send_special_out == 3'h0;
	endproperty
	a_maint_quiet: assert property (p_maint_quiet) else $error("datagram in maint");
	property p_trim_quiet;
		mode_out == 2'h3 |-> !send_measure_out;
	endproperty
	a_trim_quiet: assert property (p_trim_quiet) else $error("datagram in trim");
	property p_listing;
		$rose(mode_out == 2'h2) |-> $past(send_listing_out) or ##[0:1] send_listing_out;
	endproperty
	a_listing: assert property (p_listing) else $error("no listing on entry");
	property p_trim_ack;
		$rose(mode_out == 2'h3) |-> $past(send_trim_ack_out) or ##[0:1] send_trim_ack_out;
	endproperty
	a_trim_ack: assert property (p_trim_ack) else $error("no trim ack");
	property p_entry_idle;
		$changed(mode_out) && mode_out[1] |-> !$past(tx_busy_in) && !$past(slot_tick_in);
	endproperty
	a_entry_idle: assert property (p_entry_idle) else $error("entry while busy");
	property p_special_slot;
		send_special_out != 3'h0 |-> $past(slot_tick_in) && !$past(tx_busy_in) && !send_measure_out;
	endproperty
	a_special_slot: assert property (p_special_slot) else $error("special off slot");
	property p_measure_slot;
		send_measure_out |-> $past(slot_tick_in);
	endproperty
	a_measure_slot: assert property (p_measure_slot) else $error("measure off slot");
endmodule // imcc_top_sva
bind imcc_top imcc_top_sva chk_u (.core_clk_in, .reset_n_in, .slot_tick_in, .tx_busy_in,
	.comp_axis_in, .comp_valid_in, .latency_us_in, .adj_axis_out, .adj_valid_out,
	.latency_upper_byte_out, .latency_lower_byte_out, .send_measure_out, .send_special_out,
	.send_listing_out, .send_trim_ack_out, .mode_out);

/* File: dv/tb_imu_mode_command_control.sv */
// Self-checking bench for the mode and command controller
`timescale 1ns/1ps
module tb_imu_mode_command_control;
	logic core_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [7:0] rx_char_in;
	logic rx_valid_in;
	logic slot_tick_in = 1'b0, tx_busy_in = 1'b0, comp_valid_in = 1'b0;
	logic [23:0] comp_value_in = 24'h000000;
	logic [2:0] comp_axis_in = 3'h0;
	logic [7:0] check_fault_in = 8'h00;
	logic [15:0] latency_us_in = 16'h0000;
	logic [7:0] wb_adr_in = 8'h00;
	logic [31:0] wb_dat_in = 32'h00000000;
	logic [3:0] wb_sel_in = 4'h0;
	logic wb_we_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0;
	logic [31:0] wb_dat_out, q;
	logic wb_ack_out, adj_valid_out, send_measure_out, send_listing_out, send_trim_ack_out;
	logic incr_discard_out, unit_reset_out;
	logic [23:0] adj_value_out;
	logic [2:0] adj_axis_out, send_special_out;
	logic [7:0] status_byte_out, latency_upper_byte_out, latency_lower_byte_out;
	logic [1:0] mode_out;
	logic [3:0] seen = 4'h0;
	int num_errors = 0, check_count = 0;
	logic [7:0] cmds[5] = '{8'h4e, 8'h49, 8'h43, 8'h54, 8'h45}; // Single-letter requests
	// ----
	// Design, host and clock
	// ----
	imcc_top dut_u (.core_clk_in, .reset_n_in, .rx_char_in, .rx_valid_in, .slot_tick_in,
		.tx_busy_in, .comp_value_in, .comp_axis_in, .comp_valid_in, .check_fault_in,
		.latency_us_in, .wb_adr_in, .wb_dat_in, .wb_sel_in, .wb_we_in, .wb_cyc_in, .wb_stb_in,
		.wb_dat_out, .wb_ack_out, .adj_value_out, .adj_axis_out, .adj_valid_out,
		.status_byte_out, .latency_upper_byte_out, .latency_lower_byte_out, .send_measure_out,
		.send_special_out, .send_listing_out, .send_trim_ack_out, .incr_discard_out,
		.unit_reset_out, .mode_out);
	imcc_host_model host_u (.core_clk_in, .rx_char_out(rx_char_in), .rx_valid_out(rx_valid_in));
	// 25 ns period
	initial forever #12.5 core_clk_in = ~core_clk_in;
	// One-cycle pulses are caught here so no check can miss them
	always @(posedge core_clk_in) begin
		seen <= seen | {incr_discard_out, send_trim_ack_out, send_listing_out, unit_reset_out};
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Classic cycle: held until ack is sampled, released at that edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge core_clk_in);
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in, wb_sel_in} <= {2'b11, we, a, d, 4'hf};
		do @(posedge core_clk_in); while (wb_ack_out !== 1'b1);
		r = wb_dat_out;
		{wb_cyc_in, wb_stb_in, wb_we_in} <= 3'b000;
	endtask
	task automatic slot();
		@(posedge core_clk_in) slot_tick_in <= 1'b1;
		@(posedge core_clk_in) slot_tick_in <= 1'b0;
		#1;
	endtask
	task automatic samp(input logic [2:0] ax, input logic [23:0] v, input logic [7:0] f);
		@(posedge core_clk_in);
		{comp_valid_in, comp_axis_in, comp_value_in, check_fault_in} <= {1'b1, ax, v, f};
		@(posedge core_clk_in);
		{comp_valid_in, check_fault_in} <= 9'h000;
		#1;
	endtask
	task automatic cmd(input logic [imcc_pkg::CMD_BUF_LEN*8-1:0] w, input int n);
		host_u.send_cmd(w, n);
		repeat (4) @(posedge core_clk_in);
		#1;
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ----
	// Tests
	// ----
	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#500us;
		num_errors++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		latency_us_in <= 16'hab12;
		wb(1'b0, 8'hfc, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		chk("mode after reset", 32'h1, mode_out);
		chk("latency upper", 32'hab, latency_upper_byte_out);
		chk("latency lower", 32'h12, latency_lower_byte_out);
		wb(1'b1, imcc_pkg::ADDR_TRIM_BASE + 8'h08, 32'h00000010, q);
		samp(3'h2, 24'hfffff8, 8'h00);
		chk("trimmed value", 32'h000008, adj_value_out);
		$display("Test latency and trim done");
		wb(1'b1, imcc_pkg::ADDR_CTRL, 32'h70, q);
		samp(3'h0, 24'h0, 8'h01);
		samp(3'h1, 24'h0, 8'h04);
		slot();
		chk("status accumulated", 32'h05, status_byte_out);
		slot();
		chk("status next slot", 32'h00, status_byte_out);
		$display("Test status done");
		for (int k = 0; k < 5; k++) begin
			cmd({80'h0, cmds[k]}, 1);
			slot();
			chk("special kind", k + 1, send_special_out);
			chk("increment drop", 32'h1, incr_discard_out);
		end
		wb(1'b0, imcc_pkg::ADDR_FAULT_ACC, 32'h0, q);
		chk("fault accumulator", 32'h0, q);
		cmd(88'h4e58, 2);
		slot();
		chk("unknown silent", 32'h0, send_special_out);
		chk("measure resumes", 32'h1, send_measure_out);
		chk("no drop", 32'h0, incr_discard_out);
		cmd({80'h0, 8'h49}, 1);
		slot();
		chk("after unknown", 32'h2, send_special_out);
		wb(1'b0, imcc_pkg::ADDR_LAST_CMD, 32'h0, q);
		chk("last command", 32'h49, q);
		cmd({80'h0, 8'h52}, 1);
		chk("unit reset", 32'h1, seen[0]);
		$display("Test commands done");
		@(posedge core_clk_in) tx_busy_in <= 1'b1;
		cmd(88'h42544f4d4f4445, 7);
		chk("mode held busy", 32'h1, mode_out);
		@(posedge core_clk_in) tx_busy_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		#1;
		chk("trim mode", 32'h3, mode_out);
		chk("trim ack", 32'h1, seen[2]);
		slot();
		chk("trim quiet", 32'h0, send_measure_out);
		wb(1'b1, imcc_pkg::ADDR_CTRL, 32'h74, q);
		wb(1'b1, imcc_pkg::ADDR_CTRL, 32'h70, q);
		slot();
		chk("trim exit", 32'h1, mode_out);
		chk("measure back", 32'h1, send_measure_out);
		$display("Test trim mode done");
		cmd(88'h53455256494345_4d4f4445, 11);
		chk("maint mode", 32'h2, mode_out);
		chk("listing", 32'h1, seen[1]);
		slot();
		chk("maint quiet", 32'h0, send_measure_out);
		samp(3'h0, 24'h0, 8'h02);
		wb(1'b0, imcc_pkg::ADDR_FAULT_ACC, 32'h0, q);
		chk("fault gathered", 32'h02, q);
		wb(1'b1, imcc_pkg::ADDR_CTRL, 32'h78, q);
		wb(1'b0, imcc_pkg::ADDR_FAULT_ACC, 32'h0, q);
		chk("fault query clear", 32'h0, q);
		wb(1'b1, imcc_pkg::ADDR_CTRL, 32'h73, q);
		wb(1'b1, imcc_pkg::ADDR_CTRL, 32'h70, q);
		repeat (2) @(posedge core_clk_in);
		#1;
		chk("exit normal", 32'h1, mode_out);
		wb(1'b0, imcc_pkg::ADDR_TRIM_BASE + 8'h08, 32'h0, q);
		chk("trim kept", 32'h10, q);
		cmd(88'h53455256494345_4d4f4445, 11);
		@(posedge core_clk_in) reset_n_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		#1;
		chk("reset to init", 32'h0, mode_out);
		@(posedge core_clk_in) reset_n_in <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		#1;
		chk("normal after init", 32'h1, mode_out);
		wb(1'b0, imcc_pkg::ADDR_TRIM_BASE + 8'h08, 32'h0, q);
		chk("trim reloaded", 32'h0, q);
		$display("Test maint mode done");
		tally_and_finish();
	end
endmodule // tb_imu_mode_command_control
